// *** nsalu_core.sv ***
// Notes on behaviour
// - swap exchanges file nibbles, flags untouched
// - dest bit 0 to accumulator, 1 to file except for the literal subtract
// - subtract sets carry when difference positive
// - subtract sets carry when difference zero
// - borrow clears carry, difference wraps mod 256
module nsalu_core
  import nsalu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire nsalu_op_e opSel,
  input wire logic destSel,
  input wire logic [FADDR_W-1:0] fileAddr,
  input wire logic [DATA_W-1:0] fileRdData,
  input wire logic [DATA_W-1:0] literal,
  output logic [DATA_W-1:0] acc_q,
  output logic carry_q,
  output logic fileWrEn_q,
  output logic [FADDR_W-1:0] fileWrAddr_q,
  output logic [DATA_W-1:0] fileWrData_q
);
  // ***************************************************
  // datapath
  // ***************************************************
  logic [DATA_W-1:0] swapped;
  logic [DATA_W-1:0] subMin;
  logic [DATA_W-1:0] diff;
  logic subCarry;
  logic isSub;
  logic toFile;
  logic [DATA_W-1:0] result;

  function automatic logic [DATA_W-1:0] nibSwap(input logic [DATA_W-1:0] v);
    nibSwap = {v[NIB_W-1:0], v[DATA_W-1:NIB_W]};
  endfunction

  assign swapped = nibSwap(fileRdData);
  assign subMin = (opSel == OP_LITERAL_MINUS_ACC) ? literal : fileRdData;
  assign isSub = instrValid && (opSel == OP_REG_MINUS_ACC || opSel == OP_LITERAL_MINUS_ACC);
  // the literal form always lands in the accumulator
  assign toFile = instrValid && destSel == DEST_FILE && opSel != OP_LITERAL_MINUS_ACC
    && opSel != OP_NONE;
  assign result = (opSel == OP_NIBBLE_EXCHANGE) ? swapped : diff;

  nsalu_sub #(.WIDTH(DATA_W)) uSub
  (
    .minuend(subMin),
    .subtrahend(acc_q),
    .diff(diff),
    .carryOut(subCarry)
  );

  // ***************************************************
  // state
  // ***************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      acc_q <= ACC_RST;
    else if (instrValid && opSel != OP_NONE && !toFile)
      acc_q <= result;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      carry_q <= CARRY_RST;
    else if (isSub)
      carry_q <= subCarry;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fileWrEn_q <= 1'b0;
      fileWrAddr_q <= '0;
      fileWrData_q <= '0;
    end
    else
    begin
      fileWrEn_q <= toFile;
      if (toFile)
      begin
        fileWrAddr_q <= fileAddr;
        fileWrData_q <= result;
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  sequence swapIssue;
    instrValid && opSel == OP_NIBBLE_EXCHANGE;
  endsequence

  AST_SWAP_ACC: assert property (@(posedge sys_clk) disable iff (rst)
    swapIssue and destSel == DEST_ACC |=> acc_q == nibSwap($past(fileRdData)))
    else $error("swap to accumulator wrong");
  AST_SWAP_FILE: assert property (@(posedge sys_clk) disable iff (rst)
    swapIssue and destSel == DEST_FILE |=> fileWrEn_q && fileWrAddr_q == $past(fileAddr)
    && fileWrData_q == nibSwap($past(fileRdData)) && $stable(acc_q))
    else $error("swap to file wrong");
  AST_SWAP_FLAGS: assert property (@(posedge sys_clk) disable iff (rst)
    swapIssue |=> $stable(carry_q))
    else $error("swap changed carry");
  AST_SWAP_ONECYC: assert property (@(posedge sys_clk) disable iff (rst)
    swapIssue ##1 !instrValid |=> !fileWrEn_q)
    else $error("swap write lingered");
  AST_SUB_POS: assert property (@(posedge sys_clk) disable iff (rst)
    isSub && subMin > acc_q |=> carry_q)
    else $error("positive difference lost carry");
  AST_SUB_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    isSub && subMin == acc_q |=> carry_q)
    else $error("zero difference lost carry");
  AST_SUB_NEG: assert property (@(posedge sys_clk) disable iff (rst)
    isSub && subMin < acc_q |=> !carry_q)
    else $error("borrow kept carry");
  AST_SUB_WRAP: assert property (@(posedge sys_clk) disable iff (rst)
    instrValid && opSel == OP_LITERAL_MINUS_ACC
    |=> acc_q == 8'(($past(literal) - $past(acc_q))))
    else $error("literal difference wrong");

  // ***************************************************
  // slot checks
  // ***************************************************
  // a refused slot is the common case in a real pipeline, so it gets its own watch
  sequence idleSlot;
    !instrValid || opSel == OP_NONE;
  endsequence

  sequence regSubIssue;
    instrValid && opSel == OP_REG_MINUS_ACC;
  endsequence

  sequence litSubIssue;
    instrValid && opSel == OP_LITERAL_MINUS_ACC;
  endsequence

  AST_IDLE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    idleSlot |=> !fileWrEn_q && $stable(acc_q) && $stable(carry_q))
    else $error("refused slot changed state");

  AST_REG_SUB_ACC: assert property (@(posedge sys_clk) disable iff (rst)
    regSubIssue and destSel == DEST_ACC
    |=> acc_q == 8'(($past(fileRdData) - $past(acc_q))) && !fileWrEn_q)
    else $error("register difference to accumulator wrong");

  AST_REG_SUB_FILE: assert property (@(posedge sys_clk) disable iff (rst)
    regSubIssue and destSel == DEST_FILE
    |=> fileWrEn_q && fileWrAddr_q == $past(fileAddr)
    && fileWrData_q == 8'(($past(fileRdData) - $past(acc_q))) && $stable(acc_q))
    else $error("register difference to file wrong");

  // the literal form has no file operand, so dest must never reach the write port
  AST_LIT_NO_FILE: assert property (@(posedge sys_clk) disable iff (rst)
    litSubIssue |=> !fileWrEn_q)
    else $error("literal difference wrote a file register");

  // ***************************************************
  // register hold checks
  // ***************************************************
  // only the subtracts may move carry; anything else would corrupt branch tests
  AST_CARRY_ONLY_SUB: assert property (@(posedge sys_clk) disable iff (rst)
    !isSub |=> $stable(carry_q))
    else $error("carry moved outside a subtract");

  // a file write and an accumulator update never share a cycle
  AST_WR_EXCL_ACC: assert property (@(posedge sys_clk) disable iff (rst)
    fileWrEn_q |-> $stable(acc_q))
    else $error("accumulator moved during file write");

  // address and data are held between writes so a slow file port can relatch them
  AST_WR_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !fileWrEn_q |-> $stable(fileWrAddr_q) && $stable(fileWrData_q))
    else $error("write port moved without a write");

  // the write strobe is a single pulse unless a new file op follows
  AST_WR_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    fileWrEn_q && !toFile |=> !fileWrEn_q)
    else $error("write strobe stretched");
endmodule

// *** nsalu_pkg.sv ***
package nsalu_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int FADDR_W = 7;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // opcode select for the slice
  typedef enum logic [1:0]
  {
    OP_NONE,
    OP_NIBBLE_EXCHANGE,
    OP_REG_MINUS_ACC,
    OP_LITERAL_MINUS_ACC
  } nsalu_op_e;
endpackage

// *** nsalu_sub.sv ***
module nsalu_sub
  import nsalu_pkg::*;
#(
  parameter int WIDTH = DATA_W
)
(
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  output logic [WIDTH-1:0] diff,
  output logic carryOut
);
  logic [WIDTH:0] wide;
  // carry is the inverted borrow: set for positive or zero
  always_comb
  begin
    wide = {1'b0, minuend} - {1'b0, subtrahend};
    diff = wide[WIDTH-1:0];
    carryOut = ~wide[WIDTH];
  end
endmodule

// *** nsalu_core_tb.sv ***
module nsalu_core_tb;
  import nsalu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  nsalu_op_e opSel = OP_NONE;
  logic destSel = 1'b0;
  logic [FADDR_W-1:0] fileAddr = 7'h00;
  logic [DATA_W-1:0] fileRdData = 8'h00;
  logic [DATA_W-1:0] literal = 8'h00;
  logic [DATA_W-1:0] acc_q, fileWrData_q, accExp;
  logic carry_q, fileWrEn_q, carryExp, wrExp;
  logic [FADDR_W-1:0] fileWrAddr_q;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  nsalu_core DUT (.*);
  // ****************
  // reference model
  // ****************
  function automatic logic [7:0] swp(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // inputs move 1 ns after the edge (the first step's by nonblocking assignment at the edge itself) so the design never races the bench
  task automatic step(input logic v, nsalu_op_e op, logic d, logic [7:0] f, logic [7:0] k);
    logic [7:0] m, r;
    logic [6:0] a;
    a = 7'($urandom);
    instrValid <= v;
    opSel <= op;
    destSel <= d;
    fileAddr <= a;
    fileRdData <= f;
    literal <= k;
    wrExp = 1'b0;
    m = (op == OP_LITERAL_MINUS_ACC) ? k : f;
    r = (op == OP_NIBBLE_EXCHANGE) ? swp(f) : m - accExp;
    if (v && op != OP_NONE)
    begin
      if (op != OP_NIBBLE_EXCHANGE) carryExp = (m >= accExp);
      wrExp = (d == DEST_FILE) && (op != OP_LITERAL_MINUS_ACC);
      if (!wrExp) accExp = r;
    end
    @(posedge sys_clk);
    #1;
    chk(acc_q, accExp);
    chk({7'h00, carry_q}, {7'h00, carryExp});
    chk({7'h00, fileWrEn_q}, {7'h00, wrExp});
    if (wrExp)
    begin
      chk({1'b0, fileWrAddr_q}, {1'b0, a});
      chk(fileWrData_q, r);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      num_errors++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(32'hc3e7));
    accExp = ACC_RST;
    carryExp = CARRY_RST;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    step(1'b0, OP_NIBBLE_EXCHANGE, DEST_FILE, 8'ha5, 8'h00);
    step(1'b1, OP_LITERAL_MINUS_ACC, DEST_FILE, 8'h00, 8'h02);
    step(1'b1, OP_REG_MINUS_ACC, DEST_FILE, 8'h03, 8'h00);
    step(1'b1, OP_REG_MINUS_ACC, DEST_FILE, 8'h02, 8'h00);
    step(1'b1, OP_REG_MINUS_ACC, DEST_FILE, 8'h01, 8'h00);
    step(1'b1, OP_NIBBLE_EXCHANGE, DEST_FILE, 8'ha5, 8'h00);
    step(1'b1, OP_NIBBLE_EXCHANGE, DEST_ACC, 8'ha5, 8'h00);
    step(1'b1, OP_REG_MINUS_ACC, DEST_ACC, 8'h5a, 8'h00);
    step(1'b1, OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h00, 8'h01);
    step(1'b1, OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h00, 8'h00);
    $display("test corner done");
    repeat (300) step(1'($urandom), nsalu_op_e'(2'($urandom)), 1'($urandom), 8'($urandom),
      8'($urandom));
    $display("test random done");
    stop_test();
  end
endmodule
